//--- verilog/adc_out_pkg.sv
package adc_out_pkg;

  // ------------------------------------------------------------------
  // conversion data path
  // ------------------------------------------------------------------
  localparam int CODE_WIDTH = 12;
  localparam int LATENCY_CYCLES = 5;
  // capture stage plus the five latency stages
  localparam int PIPE_DEPTH = LATENCY_CYCLES + 1;
  localparam int SYNC_STAGES = 2;
  localparam int STRAP_WIDTH = 4;
  localparam logic [CODE_WIDTH-1:0] CODE_ZERO = 12'h000;
  localparam logic [CODE_WIDTH-1:0] CODE_FULL = 12'hFFF;

  // strap positions inside the synchronised strap vector
  localparam int STRAP_MODE_LOW = 0;
  localparam int STRAP_MODE_HIGH = 1;
  localparam int STRAP_REF_SEL = 2;
  localparam int STRAP_OE_N = 3;
  localparam logic [STRAP_WIDTH-1:0] STRAP_RESET = 4'h9;

  // decode of {mode_select_high, mode_select_low}
  typedef enum logic [1:0] {
    MODE_POWER_DOWN = 2'b00,
    MODE_GAIN_ONE = 2'b01,
    MODE_GAIN_HALF = 2'b10,
    MODE_UNUSED = 2'b11
  } conv_mode_t;

  typedef struct packed {
    logic valid;
    logic over;
    logic [CODE_WIDTH-1:0] code;
  } sample_word_t;

  localparam int WORD_WIDTH = CODE_WIDTH + 2;
  localparam sample_word_t WORD_RESET = '{valid: 1'b0, over: 1'b0, code: CODE_ZERO};

  // ------------------------------------------------------------------
  // register map, byte addresses
  // ------------------------------------------------------------------
  localparam int ADDR_WIDTH = 5;
  localparam logic [ADDR_WIDTH-1:0] CTRL_OFFSET = 5'h00;
  localparam logic [ADDR_WIDTH-1:0] STATE_OFFSET = 5'h04;
  localparam logic [ADDR_WIDTH-1:0] IRQ_STATUS_OFFSET = 5'h08;
  localparam logic [ADDR_WIDTH-1:0] IRQ_MASK_OFFSET = 5'h0C;
  localparam logic [ADDR_WIDTH-1:0] LAST_SAMPLE_OFFSET = 5'h10;

  localparam int CTRL_STANDBY_BIT = 0;
  localparam logic CTRL_RESET = 1'b0;

  localparam int IRQ_WIDTH = 3;
  localparam int IRQ_OVER_BIT = 0;
  localparam int IRQ_MODE_BIT = 1;
  localparam int IRQ_UNUSED_BIT = 2;
  localparam logic [IRQ_WIDTH-1:0] IRQ_STATUS_RESET = 3'h0;
  localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 3'h0;

  localparam logic [31:0] READ_ZERO = 32'h00000000;

endpackage

//--- verilog/strap_sync.sv
`timescale 1ns/100ps

// two flip-flop synchroniser for slow pins; first stage feeds only the second
module strap_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // ------------------------------------------------------------------
  // synchroniser chain
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meta_reg <= RESET_VALUE;
      sync_reg <= RESET_VALUE;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign pin_sync = sync_reg;

endmodule // strap_sync

//--- verilog/word_pipe.sv
`timescale 1ns/100ps

// fixed-depth shift pipeline; output is the last stage register
module word_pipe #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] word_in,
  output logic [WIDTH-1:0] word_out
);

  logic [DEPTH-1:0][WIDTH-1:0] stage_reg;
  logic [DEPTH-1:0][WIDTH-1:0] stage_next;

  // ------------------------------------------------------------------
  // shift one stage per clock
  // ------------------------------------------------------------------
  always_comb begin
    stage_next[0] = word_in;
    for (int i = 1; i < DEPTH; i++) begin
      stage_next[i] = stage_reg[i-1];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= stage_next;
    end
  end

  assign word_out = stage_reg[DEPTH-1];

endmodule // word_pipe

//--- verilog/adc_out_ctrl.sv
// Design decisions made here: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps

// Behaviour
// - capture one sample per rising clock edge
// - result appears five rising edges later
// - mode straps decode; 11 is never applied
// - mode 00 powers down, no valid words
// - 12-bit result driven on parallel bus
// - output enable low drives, high floats
// - over-range flag travels with its sample
// - unsigned straight binary, clamped at extremes
// - output enable independent of sample timing
// - data, over-range and valid outputs change after the falling edge
module adc_out_ctrl (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [11:0] conv_code,
  input wire logic conv_above_upper,
  input wire logic conv_below_lower,
  input wire logic mode_select_low,
  input wire logic mode_select_high,
  input wire logic reference_source_select,
  input wire logic output_enable_n,
  output logic [11:0] sample_data_bus,
  output logic sample_data_oe,
  output logic over_range_pin,
  output logic sample_valid,
  output logic reference_external,
  output logic analog_power_up,
  output logic gain_half,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq
);

  // ------------------------------------------------------------------
  // strap synchronisation
  // ------------------------------------------------------------------
  logic [adc_out_pkg::STRAP_WIDTH-1:0] strap_pins;
  logic [adc_out_pkg::STRAP_WIDTH-1:0] strap_sync;
  adc_out_pkg::conv_mode_t mode_now;
  logic standby_reg;
  logic running;

  assign strap_pins = {output_enable_n, reference_source_select, mode_select_high,
                       mode_select_low};

  strap_sync #(
    .WIDTH(adc_out_pkg::STRAP_WIDTH),
    .RESET_VALUE(adc_out_pkg::STRAP_RESET)
  ) u_strap_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_in(strap_pins),
    .pin_sync(strap_sync)
  );

  assign mode_now = adc_out_pkg::conv_mode_t'({strap_sync[adc_out_pkg::STRAP_MODE_HIGH],
                                               strap_sync[adc_out_pkg::STRAP_MODE_LOW]});
  // power down unless a legal gain mode with standby clear
  assign running = ((mode_now == adc_out_pkg::MODE_GAIN_ONE) ||
                    (mode_now == adc_out_pkg::MODE_GAIN_HALF)) && !standby_reg;

  // ------------------------------------------------------------------
  // capture and pipeline
  // ------------------------------------------------------------------
  adc_out_pkg::sample_word_t cap_word;
  adc_out_pkg::sample_word_t pipe_out;

  // clamp out-of-span samples to the end codes
  // flag tagged onto the same word
  always_comb begin
    cap_word = adc_out_pkg::WORD_RESET;
    if (running) begin
      cap_word.valid = 1'b1;
      cap_word.over = conv_above_upper | conv_below_lower;
      if (conv_above_upper) begin
        cap_word.code = adc_out_pkg::CODE_FULL;
      end else if (conv_below_lower) begin
        cap_word.code = adc_out_pkg::CODE_ZERO;
      end else begin
        cap_word.code = conv_code;
      end
    end
  end

  // stage zero takes a sample every rising edge
  // five further stages give the fixed latency
  word_pipe #(
    .WIDTH(adc_out_pkg::WORD_WIDTH),
    .DEPTH(adc_out_pkg::PIPE_DEPTH)
  ) u_word_pipe (
    .clk_sys(clk_sys),
    .reset(reset),
    .word_in(cap_word),
    .word_out(pipe_out)
  );

  // ------------------------------------------------------------------
  // output stage on the falling edge
  // ------------------------------------------------------------------
  logic [11:0] data_reg;
  logic [11:0] data_next;
  logic over_reg;
  logic over_next;
  logic valid_reg;
  logic valid_next;

  // result onto the parallel bus, msb on line 11
  always_comb begin
    data_next = pipe_out.code;
    over_next = pipe_out.over;
    valid_next = pipe_out.valid;
  end

  // half a cycle of setup before the capturing rising edge
  always_ff @(negedge clk_sys or posedge reset) begin
    if (reset) begin
      data_reg <= adc_out_pkg::CODE_ZERO;
      over_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      data_reg <= data_next;
      over_reg <= over_next;
      valid_reg <= valid_next;
    end
  end

  // ------------------------------------------------------------------
  // pin-facing status levels
  // ------------------------------------------------------------------
  logic oe_reg;
  logic oe_next;
  logic ref_ext_reg;
  logic ref_ext_next;
  logic power_reg;
  logic power_next;
  logic half_reg;
  logic half_next;
  adc_out_pkg::conv_mode_t mode_prev_reg;

  always_comb begin
    oe_next = !strap_sync[adc_out_pkg::STRAP_OE_N];
    ref_ext_next = strap_sync[adc_out_pkg::STRAP_REF_SEL];
    power_next = running;
    half_next = running && (mode_now == adc_out_pkg::MODE_GAIN_HALF);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      oe_reg <= 1'b0;
      ref_ext_reg <= 1'b0;
      power_reg <= 1'b0;
      half_reg <= 1'b0;
      // matches the synchroniser reset so release raises no false mode event
      mode_prev_reg <= adc_out_pkg::MODE_GAIN_ONE;
    end else begin
      oe_reg <= oe_next;
      ref_ext_reg <= ref_ext_next;
      power_reg <= power_next;
      half_reg <= half_next;
      mode_prev_reg <= mode_now;
    end
  end

  // ------------------------------------------------------------------
  // register slave, one wait cycle per access
  // ------------------------------------------------------------------
  logic wait_reg;
  logic wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic standby_next;
  logic [adc_out_pkg::IRQ_WIDTH-1:0] irq_status_reg;
  logic [adc_out_pkg::IRQ_WIDTH-1:0] irq_status_next;
  logic [adc_out_pkg::IRQ_WIDTH-1:0] irq_mask_reg;
  logic [adc_out_pkg::IRQ_WIDTH-1:0] irq_mask_next;
  logic [adc_out_pkg::IRQ_WIDTH-1:0] irq_events;
  logic irq_reg;
  logic irq_next;
  logic access_done;

  assign access_done = (avs_read || avs_write) && !wait_reg;

  // events: over-range output word, any mode change, the unused code
  always_comb begin
    irq_events = '0;
    irq_events[adc_out_pkg::IRQ_OVER_BIT] = pipe_out.valid && pipe_out.over;
    irq_events[adc_out_pkg::IRQ_MODE_BIT] = mode_now != mode_prev_reg;
    irq_events[adc_out_pkg::IRQ_UNUSED_BIT] = mode_now == adc_out_pkg::MODE_UNUSED;
  end

  // read data is built while waitrequest is still high
  always_comb begin
    wait_next = 1'b1;
    rdata_next = rdata_reg;
    standby_next = standby_reg;
    irq_mask_next = irq_mask_reg;
    irq_status_next = irq_status_reg | irq_events;
    if ((avs_read || avs_write) && wait_reg) begin
      wait_next = 1'b0;
      unique case (avs_address)
        adc_out_pkg::CTRL_OFFSET: rdata_next = {31'h00000000, standby_reg};
        adc_out_pkg::STATE_OFFSET: rdata_next = {27'h0000000, running, oe_reg,
                                                 ref_ext_reg, mode_now};
        adc_out_pkg::IRQ_STATUS_OFFSET: rdata_next = {29'h00000000, irq_status_reg};
        adc_out_pkg::IRQ_MASK_OFFSET: rdata_next = {29'h00000000, irq_mask_reg};
        adc_out_pkg::LAST_SAMPLE_OFFSET: rdata_next = {18'h00000, valid_reg, over_reg,
                                                       data_reg};
        default: rdata_next = adc_out_pkg::READ_ZERO;
      endcase
    end
    if (access_done && avs_write) begin
      if (avs_address == adc_out_pkg::CTRL_OFFSET) begin
        standby_next = avs_writedata[adc_out_pkg::CTRL_STANDBY_BIT];
      end
      if (avs_address == adc_out_pkg::IRQ_MASK_OFFSET) begin
        irq_mask_next = avs_writedata[adc_out_pkg::IRQ_WIDTH-1:0];
      end
    end
    // read clears, but an event in the same cycle stays set
    if (access_done && avs_read && (avs_address == adc_out_pkg::IRQ_STATUS_OFFSET)) begin
      irq_status_next = irq_events;
    end
    irq_next = |(irq_status_next & irq_mask_next);
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wait_reg <= 1'b1;
      rdata_reg <= adc_out_pkg::READ_ZERO;
      standby_reg <= adc_out_pkg::CTRL_RESET;
      irq_status_reg <= adc_out_pkg::IRQ_STATUS_RESET;
      irq_mask_reg <= adc_out_pkg::IRQ_MASK_RESET;
      irq_reg <= 1'b0;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      standby_reg <= standby_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      irq_reg <= irq_next;
    end
  end

  assign sample_data_bus = data_reg;
  assign sample_data_oe = oe_reg;
  assign over_range_pin = over_reg;
  assign sample_valid = valid_reg;
  assign reference_external = ref_ext_reg;
  assign analog_power_up = power_reg;
  assign gain_half = half_reg;
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign irq = irq_reg;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  sequence cap_taken;
    cap_word.valid;
  endsequence

  sequence word_emerges;
    ##6 pipe_out.valid;
  endsequence

  chk_capture_each_edge: assert property (
    @(posedge clk_sys) disable iff (reset)
    running |-> cap_taken)
    else $error("running but no sample captured");

  chk_latency_five: assert property (
    @(posedge clk_sys) disable iff (reset)
    (!reset ##0 cap_taken) |-> word_emerges)
    else $error("captured word did not emerge after latency");

  chk_latency_data: assert property (
    @(posedge clk_sys) disable iff (reset)
    !reset |-> ##6 (pipe_out == $past(cap_word, 6)))
    else $error("pipeline word does not match capture");

  chk_unused_flagged: assert property (
    @(posedge clk_sys) disable iff (reset)
    (mode_now == adc_out_pkg::MODE_UNUSED) |=> irq_status_reg[adc_out_pkg::IRQ_UNUSED_BIT])
    else $error("unused mode not flagged");

  chk_power_down_quiet: assert property (
    @(posedge clk_sys) disable iff (reset)
    (!running)[*7] |-> !pipe_out.valid && !power_reg)
    else $error("valid word during power down");

  chk_bus_follows: assert property (
    @(negedge clk_sys) disable iff (reset)
    ##1 (sample_data_bus == $past(pipe_out.code)))
    else $error("data bus does not carry pipeline code");

  chk_enable_level: assert property (
    @(posedge clk_sys) disable iff (reset)
    ##1 (sample_data_oe == !$past(strap_sync[adc_out_pkg::STRAP_OE_N])))
    else $error("output enable wrong level");

  chk_over_extreme: assert property (
    @(negedge clk_sys) disable iff (reset)
    over_range_pin |-> (sample_data_bus == adc_out_pkg::CODE_FULL) ||
                       (sample_data_bus == adc_out_pkg::CODE_ZERO))
    else $error("over-range without end code");

  chk_clamp_high: assert property (
    @(posedge clk_sys) disable iff (reset)
    (!reset && running && conv_above_upper) |-> ##6 (pipe_out.code == adc_out_pkg::CODE_FULL))
    else $error("above-span sample not clamped to full scale");

  // a falling-edge update shows the current pipe word at the next rising edge
  chk_falling_only: assert property (
    @(posedge clk_sys) disable iff (reset)
    !reset |-> (sample_data_bus == pipe_out.code))
    else $error("data bus moved on a rising edge");

endmodule // adc_out_ctrl

//--- tb/sample_capture.sv
`timescale 1ns/100ps

// capture side: latches the resolved bus each rising edge and marks stale words
module sample_capture (
  input wire logic clk_sys,
  input wire logic [11:0] bus_wire,
  input wire logic over_wire,
  input wire logic valid_in,
  input wire logic live_in,
  input wire logic [1:0] mode_pins,
  output adc_out_pkg::sample_word_t cap_word,
  output logic cap_live,
  output logic cap_keep
);
  logic [1:0] mode_last = 2'h0;
  logic [2:0] drop_cnt = 3'h5;

  always @(posedge clk_sys) begin
    cap_word <= '{valid: valid_in, over: over_wire, code: bus_wire};
    cap_live <= live_in;
    mode_last <= mode_pins;
    cap_keep <= (drop_cnt == 3'h0);
    if (mode_pins != mode_last) begin
      drop_cnt <= 3'h5;
    end else if (drop_cnt != 3'h0) begin
      drop_cnt <= drop_cnt - 3'h1;
    end
  end
endmodule // sample_capture

//--- tb/tb_top.sv
`timescale 1ns/100ps

module tb_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [11:0] conv_code = 12'h000;
  logic conv_above_upper = 1'b0;
  logic conv_below_lower = 1'b0;
  logic [1:0] mode = 2'h1;
  logic ref_sel = 1'b0;
  logic oe_n = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata, rd, r;
  logic [11:0] sample_data_bus, bus_wire, last_bus = 12'h000;
  logic sample_data_oe, over_range_pin, sample_valid, reference_external;
  logic analog_power_up, gain_half, avs_waitrequest, irq, over_wire;
  logic last_over = 1'b0;
  logic cap_live, cap_keep;
  logic standby = 1'b0;
  logic [2:0] key_last = 3'h0;
  adc_out_pkg::sample_word_t cap_word;
  adc_out_pkg::sample_word_t hist [0:6];
  int n_fail = 0;
  int n_checks = 0;
  int seed = 56;
  int cycles = 0;
  int settle = 0;
  int pat = 0;

  // --------------------------------------------------------------
  // clock, wire resolution, instances
  // --------------------------------------------------------------
  // continuous sample clock
  always #50 clk_sys = ~clk_sys;

  // a released bus shows the inverse of its last level, never a stale copy
  always @(posedge clk_sys) begin
    if (sample_data_oe) begin
      last_bus <= sample_data_bus;
      last_over <= over_range_pin;
    end
  end
  assign bus_wire = sample_data_oe ? sample_data_bus : ~last_bus;
  assign over_wire = sample_data_oe ? over_range_pin : ~last_over;

  adc_out_ctrl i_dut (
    .clk_sys(clk_sys), .reset(reset), .conv_code(conv_code),
    .conv_above_upper(conv_above_upper), .conv_below_lower(conv_below_lower),
    .mode_select_low(mode[0]), .mode_select_high(mode[1]),
    .reference_source_select(ref_sel), .output_enable_n(oe_n),
    .sample_data_bus(sample_data_bus), .sample_data_oe(sample_data_oe),
    .over_range_pin(over_range_pin), .sample_valid(sample_valid),
    .reference_external(reference_external), .analog_power_up(analog_power_up),
    .gain_half(gain_half), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq)
  );

  sample_capture i_cap (
    .clk_sys(clk_sys), .bus_wire(bus_wire), .over_wire(over_wire),
    .valid_in(sample_valid), .live_in(sample_data_oe), .mode_pins(mode),
    .cap_word(cap_word), .cap_live(cap_live), .cap_keep(cap_keep)
  );

  // --------------------------------------------------------------
  // expectation and checking helpers
  // --------------------------------------------------------------
  function automatic adc_out_pkg::sample_word_t expw(input logic [11:0] c, input logic a,
      input logic b, input logic [1:0] m, input logic s);
    expw = adc_out_pkg::WORD_RESET;
    if (!s && (m == 2'b01 || m == 2'b10)) begin
      expw = '{valid: 1'b1, over: a | b, code: a ? 12'hFFF : (b ? 12'h000 : c)};
    end
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one bus access; the request stands until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do begin
      @(posedge clk_sys);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 20);
    if (t >= 20) chk("waitrequest", 32'h00000000, 32'h00000001);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(nm, e, rd);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // --------------------------------------------------------------
  // stimulus, history and stream monitor
  // --------------------------------------------------------------
  // pattern 1 holds over the top, 2 under the bottom, 3 never over
  always @(posedge clk_sys) begin
    if (!reset) begin
      r = $random(seed);
      conv_code <= (pat == 2) ? 12'h5A5 : r[11:0];
      conv_above_upper <= (pat == 1) || (pat == 0 && r[15:12] == 4'h0);
      conv_below_lower <= (pat == 2) || (pat == 0 && r[15:12] == 4'h1);
    end
  end

  // settle restarts on any mode change so stale pipeline words are skipped
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 20000) begin
      n_fail++;
      wrap_up();
    end
    hist[0] <= expw(conv_code, conv_above_upper, conv_below_lower, mode, standby);
    for (int i = 1; i < 7; i++) hist[i] <= hist[i-1];
    key_last <= {standby, mode};
    settle <= ({standby, mode} != key_last) ? 0 : settle + 1;
  end

  always @(negedge clk_sys) begin
    if (!reset && settle > 14 && cap_live === 1'b1 && cap_keep === 1'b1) begin
      chk("sample word", {18'h00000, hist[6]}, {18'h00000, cap_word});
    end
  end

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    rchk("ctrl", adc_out_pkg::CTRL_OFFSET, 32'h00000000);
    rchk("status", adc_out_pkg::IRQ_STATUS_OFFSET, 32'h00000000);
    rchk("mask", adc_out_pkg::IRQ_MASK_OFFSET, 32'h00000000);
    rchk("unmapped", 5'h14, 32'h00000000);
    chk("oe after reset", 32'h00000000, sample_data_oe);
    $display("test reset values done");
    oe_n <= 1'b0;
    wt(40);
    chk("power up", 32'h00000001, analog_power_up);
    chk("gain half", 32'h00000000, gain_half);
    chk("oe on", 32'h00000001, sample_data_oe);
    $display("test gain one stream done");
    mode <= 2'b10;
    ref_sel <= 1'b1;
    wt(40);
    chk("gain half", 32'h00000001, gain_half);
    chk("ref external", 32'h00000001, reference_external);
    rchk("state", adc_out_pkg::STATE_OFFSET, 32'h0000001E);
    $display("test gain half stream done");
    bus(1'b1, adc_out_pkg::IRQ_MASK_OFFSET, 32'h00000001);
    bus(1'b0, adc_out_pkg::IRQ_STATUS_OFFSET, 32'h00000000);
    pat <= 1;
    wt(20);
    chk("irq over", 32'h00000001, irq);
    pat <= 2;
    wt(20);
    pat <= 3;
    wt(10);
    rchk("status over", adc_out_pkg::IRQ_STATUS_OFFSET, 32'h00000001);
    rchk("status cleared", adc_out_pkg::IRQ_STATUS_OFFSET, 32'h00000000);
    chk("irq cleared", 32'h00000000, irq);
    $display("test over-range done");
    mode <= 2'b00;
    wt(30);
    chk("power down", 32'h00000000, analog_power_up);
    mode <= 2'b11;
    wt(30);
    rchk("status modes", adc_out_pkg::IRQ_STATUS_OFFSET, 32'h00000006);
    mode <= 2'b01;
    wt(30);
    $display("test power-down modes done");
    bus(1'b1, adc_out_pkg::CTRL_OFFSET, 32'h00000001);
    standby <= 1'b1;
    rchk("ctrl set", adc_out_pkg::CTRL_OFFSET, 32'h00000001);
    bus(1'b1, adc_out_pkg::STATE_OFFSET, 32'h000000FF);
    wt(30);
    chk("standby power", 32'h00000000, analog_power_up);
    rchk("state standby", adc_out_pkg::STATE_OFFSET, 32'h0000000D);
    bus(1'b1, adc_out_pkg::CTRL_OFFSET, 32'h00000000);
    standby <= 1'b0;
    wt(30);
    $display("test standby done");
    oe_n <= 1'b1;
    wt(2);
    #1 chk("oe held", 32'h00000001, sample_data_oe);
    wt(1);
    #1 chk("oe released", 32'h00000000, sample_data_oe);
    $display("test output enable done");
    wrap_up();
  end
endmodule // tb_top
